// File: core/sauf_top.sv
// serial unit front end: clock gate, shared prescaler, data buffers
// assumes sfr strobes are one-cycle pulses synchronous to clock
//
// Operation
// R1: each channel has an eight-bit shifter, parallel to serial and back
// R2: received word moves from the shifter into the channel buffer
// R3: buffered transmit word loads into the shifter and shifts out
// R4: shifter has no address; data passes only through the buffer
// R5: data-length bit selects seven-bit or eight-bit words, low aligned
// R6: software writes a buffer only while its channel is enabled
// R7: reset clears each channel buffer to zero
// R8: one buffer serves clocked-serial, async receive or transmit data
// R9: software sets the unit gate bit before using the unit
// R10: gate bit low stops the unit, holds reset, blocks writes
// R11: gate bit low returns unit registers to defaults, ignoring writes
// R12: gate bit high clocks the unit and allows reads and writes
// R13: software keeps unused enable-register bits at zero
// R14: select register upper nibble sets second clock, lower first
// R15: field value k divides the system clock by two to the k
// R16: software leaves the select register alone while channels run
// R17: reset clears the select register, both clocks undivided
// R18: software stops both channels before changing the system clock
// R19: reset clears the peripheral enable register
// R20: enable register takes bit or byte writes, others byte writes
// R21: per-channel select bit picks first or second shared clock
// R22: idle enabled transmitter loads a written word on next tick
module sauf_top
  import sauf_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic [19:0]              sfr_addr,
  input  wire logic                     sfr_wr,
  input  wire logic                     sfr_rd,
  input  wire logic [7:0]               sfr_wdata,
  input  wire logic [7:0]               sfr_wmask,
  output logic      [7:0]               sfr_rdata,
  output logic      [7:0]               peripheral_clock_gate,
  input  wire logic [SAUF_CHANNELS-1:0] channel_enabled_flag,
  input  wire logic [SAUF_CHANNELS-1:0] channel_transmit,
  input  wire logic [SAUF_CHANNELS-1:0] data_length_select,
  input  wire logic [SAUF_CHANNELS-1:0] channel_clock_select,
  input  wire logic [SAUF_CHANNELS-1:0] serial_in,
  output logic      [SAUF_CHANNELS-1:0] serial_out,
  output logic      [SAUF_CHANNELS-1:0] rx_done,
  output logic      [SAUF_CHANNELS-1:0] tx_loaded,
  output logic      [SAUF_CHANNELS-1:0] shifter_busy
);

  // ****************************************
  // unit clock gate
  // ****************************************
  logic       unit_on;
  logic       unit_clear;
  logic [7:0] shared_prescaler_select_q;
  logic       wr_gate;
  logic       wr_presel;
  logic       first_shared_clock;
  logic       second_shared_clock;

  assign unit_on    = peripheral_clock_gate[SAUF_GATE_BIT];
  // R10: unit held in reset while gated off
  assign unit_clear = !rst_n || !unit_on;
  assign wr_gate    = sfr_wr && (sfr_addr == SAUF_ADDR_GATE);
  // R11: writes ignored while gated off
  assign wr_presel  = sfr_wr && unit_on && (sfr_addr == SAUF_ADDR_PRESEL);

  // R19: reset clears the enable register
  // R20: masked write gives single-bit access
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      peripheral_clock_gate <= SAUF_RST_GATE;
    else if (wr_gate)
      peripheral_clock_gate <= (peripheral_clock_gate & ~sfr_wmask)
                             | (sfr_wdata & sfr_wmask);
  end

  // ****************************************
  // shared prescaler select
  // ****************************************
  // R17: reset gives undivided clocks
  // R11: gated off returns to default
  always_ff @(posedge clock)
  begin
    if (unit_clear)
      shared_prescaler_select_q <= SAUF_RST_PRESEL;
    else if (wr_presel)
      shared_prescaler_select_q <= sfr_wdata;
  end

  // R14: nibbles pick the two clocks
  sauf_prescaler u_prescaler
  (
    .clock                      (clock),
    .clear                      (unit_clear),
    .first_clock_divider_field  (
      shared_prescaler_select_q[SAUF_FIRST_LSB +: SAUF_FIELD_W]),
    .second_clock_divider_field (
      shared_prescaler_select_q[SAUF_SECOND_LSB +: SAUF_FIELD_W]),
    .first_shared_clock         (first_shared_clock),
    .second_shared_clock        (second_shared_clock)
  );

  // ****************************************
  // channel buffers and shifters
  // ****************************************
  logic [SAUF_WORD_W-1:0] channel_data_buffer_q [SAUF_CHANNELS];
  logic [19:0]            buf_addr              [SAUF_CHANNELS];

  assign buf_addr[0] = SAUF_ADDR_BUF0;
  assign buf_addr[1] = SAUF_ADDR_BUF1;

  genvar n;
  generate
    for (n = 0; n < SAUF_CHANNELS; n++)
    begin : g_chan
      logic                   wr_buf;
      logic                   tick;
      logic                   pending_q;
      logic                   taken;
      logic                   rx_valid;
      logic [SAUF_WORD_W-1:0] rx_word;
      logic [SAUF_WORD_W-1:0] wr_word;

      // R6: stopped-channel writes are dropped
      // R4: only path to shifter data
      assign wr_buf = sfr_wr && unit_on && channel_enabled_flag[n]
                   && (sfr_addr == buf_addr[n]);
      // R5: seven-bit words keep bit 7 clear
      assign wr_word = data_length_select[n] ? sfr_wdata
                                             : {1'b0, sfr_wdata[6:0]};
      // R21: per-channel clock choice
      assign tick = channel_clock_select[n] ? second_shared_clock
                                            : first_shared_clock;

      // R7: reset clears buffer
      // R8: one buffer for either direction
      always_ff @(posedge clock)
      begin
        if (unit_clear)
          channel_data_buffer_q[n] <= SAUF_RST_BUF;
        else if (wr_buf)
          channel_data_buffer_q[n] <= wr_word;
        else if (rx_valid)
          channel_data_buffer_q[n] <= rx_word;
      end

      // a write landing with the load keeps the new word pending
      always_ff @(posedge clock)
      begin
        if (unit_clear || !channel_enabled_flag[n])
          pending_q <= 1'b0;
        else if (wr_buf && channel_transmit[n])
          pending_q <= 1'b1;
        else if (taken)
          pending_q <= 1'b0;
      end

      // R1: eight-bit shifter per channel
      sauf_shifter u_shifter
      (
        .clock        (clock),
        .clear        (unit_clear),
        .tick         (tick),
        .enabled      (channel_enabled_flag[n]),
        .transmit     (channel_transmit[n]),
        .long_word    (data_length_select[n]),
        .load_pending (pending_q),
        .load_word    (channel_data_buffer_q[n]),
        .serial_in    (serial_in[n]),
        .serial_out   (serial_out[n]),
        .load_taken   (taken),
        .rx_valid     (rx_valid),
        .rx_word      (rx_word),
        .busy         (shifter_busy[n])
      );

      assign rx_done[n]   = rx_valid;
      assign tx_loaded[n] = taken;
    end
  endgenerate

  // ****************************************
  // register read port
  // ****************************************
  // R12: reads valid only with the gate on
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      if (sfr_addr == SAUF_ADDR_GATE)
        sfr_rdata <= peripheral_clock_gate;
      else if (sfr_addr == SAUF_ADDR_PRESEL)
        sfr_rdata <= shared_prescaler_select_q;
      else if (sfr_addr == SAUF_ADDR_BUF0)
        sfr_rdata <= channel_data_buffer_q[0];
      else if (sfr_addr == SAUF_ADDR_BUF1)
        sfr_rdata <= channel_data_buffer_q[1];
      else
        sfr_rdata <= 8'h00;
    end
  end

endmodule

// File: core/sauf_pkg.sv
// constants shared by the serial unit front end
// assumes an 8-bit special-function register bus with 20-bit addresses
package sauf_pkg;

  // ****************************************
  // register addresses and reset values
  // ****************************************
  localparam logic [19:0] SAUF_ADDR_GATE   = 20'hF00F0;
  localparam logic [19:0] SAUF_ADDR_PRESEL = 20'hF0126;
  localparam logic [19:0] SAUF_ADDR_BUF0   = 20'hFFF10;
  localparam logic [19:0] SAUF_ADDR_BUF1   = 20'hFFF12;
  localparam logic [7:0]  SAUF_RST_GATE    = 8'h00;
  localparam logic [7:0]  SAUF_RST_PRESEL  = 8'h00;
  localparam logic [7:0]  SAUF_RST_BUF     = 8'h00;

  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int SAUF_GATE_BIT   = 2;
  localparam int SAUF_FIRST_LSB  = 0;
  localparam int SAUF_SECOND_LSB = 4;
  localparam int SAUF_FIELD_W    = 4;
  localparam int SAUF_DIV_W      = 15;
  localparam int SAUF_CHANNELS   = 2;
  localparam int SAUF_WORD_W     = 8;

  // ****************************************
  // bit counts per word
  // ****************************************
  localparam logic [3:0] SAUF_BITS_SHORT = 4'h7;
  localparam logic [3:0] SAUF_BITS_LONG  = 4'h8;

  typedef enum logic [0:0] {SAUF_IDLE, SAUF_SHIFT} sauf_shift_state_t;

endpackage

// File: core/sauf_prescaler.sv
// shared prescaler: two operation-clock tick streams from the system clock
// assumes sync clear is held whenever the unit clock gate is off
module sauf_prescaler
  import sauf_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    clear,
  input  wire logic [SAUF_FIELD_W-1:0] first_clock_divider_field,
  input  wire logic [SAUF_FIELD_W-1:0] second_clock_divider_field,
  output logic                         first_shared_clock,
  output logic                         second_shared_clock
);

  logic [SAUF_DIV_W-1:0] count_q;
  logic [15:0]           hit;

  always_ff @(posedge clock)
  begin
    if (clear)
      count_q <= '0;
    else
      count_q <= count_q + 15'h0001;
  end

  // ****************************************
  // one hit per power-of-two divide ratio
  // ****************************************
  assign hit[0] = 1'b1;
  genvar k;
  generate
    for (k = 1; k < 16; k++)
    begin : g_div
      assign hit[k] = &count_q[k-1:0];
    end
  endgenerate

  // R15: divide by two to the k
  always_ff @(posedge clock)
  begin
    if (clear)
    begin
      first_shared_clock  <= 1'b0;
      second_shared_clock <= 1'b0;
    end
    else
    begin
      first_shared_clock  <= hit[first_clock_divider_field];
      second_shared_clock <= hit[second_clock_divider_field];
    end
  end

endmodule

// File: core/sauf_shifter.sv
// one channel's 8-bit shifter, lsb first, one bit per operation tick
// assumes the owner keeps the buffer and a pending-load flag
module sauf_shifter
  import sauf_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   clear,
  input  wire logic                   tick,
  input  wire logic                   enabled,
  input  wire logic                   transmit,
  input  wire logic                   long_word,
  input  wire logic                   load_pending,
  input  wire logic [SAUF_WORD_W-1:0] load_word,
  input  wire logic                   serial_in,
  output logic                        serial_out,
  output logic                        load_taken,
  output logic                        rx_valid,
  output logic [SAUF_WORD_W-1:0]      rx_word,
  output logic                        busy
);

  sauf_shift_state_t        state_q;
  logic [SAUF_WORD_W-1:0]   shreg_q;
  logic [3:0]               left_q;
  logic [SAUF_WORD_W-1:0]   rx_next;
  logic [3:0]               word_bits;

  assign word_bits = long_word ? SAUF_BITS_LONG : SAUF_BITS_SHORT;
  assign rx_next   = {serial_in, shreg_q[SAUF_WORD_W-1:1]};

  always_ff @(posedge clock)
  begin
    if (clear || !enabled)
    begin
      state_q    <= SAUF_IDLE;
      shreg_q    <= '0;
      left_q     <= '0;
      serial_out <= 1'b1;
      load_taken <= 1'b0;
      rx_valid   <= 1'b0;
      rx_word    <= '0;
      busy       <= 1'b0;
    end
    else
    begin
      load_taken <= 1'b0;
      rx_valid   <= 1'b0;
      unique case (state_q)
        SAUF_IDLE:
        begin
          // R22: load on next tick
          if (tick && transmit && load_pending)
          begin
            // R3: buffer into shifter
            shreg_q    <= load_word >> 1;
            serial_out <= load_word[0];
            // one tick per bit left, plus the tick that ends the last bit
            left_q     <= word_bits;
            busy       <= 1'b1;
            load_taken <= 1'b1;
            state_q    <= SAUF_SHIFT;
          end
          else if (tick && !transmit)
          begin
            shreg_q <= rx_next;
            left_q  <= word_bits - 4'h1;
            busy    <= 1'b1;
            state_q <= SAUF_SHIFT;
          end
        end
        SAUF_SHIFT:
        begin
          if (tick)
          begin
            if (transmit)
            begin
              // a finished transmit leaves the line high while idle
              serial_out <= (left_q == 4'h1) ? 1'b1 : shreg_q[0];
              shreg_q    <= shreg_q >> 1;
            end
            else
              shreg_q <= rx_next;
            left_q <= left_q - 4'h1;
            if (left_q == 4'h1 || left_q == 4'h0)
            begin
              state_q <= SAUF_IDLE;
              busy    <= 1'b0;
              // R2: word to buffer
              // R5: short word right aligned
              if (!transmit)
              begin
                rx_valid <= 1'b1;
                rx_word  <= long_word ? rx_next : {1'b0, rx_next[7:1]};
              end
            end
          end
        end
      endcase
    end
  end

endmodule

// File: test/sauf_assertions.sv
// checker on the serial unit front end top ports
// assumes a single clock and sync active-low reset
module sauf_assertions
  import sauf_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [19:0] sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_wmask,
  input wire logic [7:0]  sfr_rdata,
  input wire logic [7:0]  peripheral_clock_gate,
  input wire logic [1:0]  channel_enabled_flag,
  input wire logic [1:0]  channel_transmit,
  input wire logic [1:0]  rx_done,
  input wire logic [1:0]  tx_loaded,
  input wire logic [1:0]  shifter_busy
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  wire mapped = sfr_addr inside {SAUF_ADDR_GATE, SAUF_ADDR_PRESEL,
                                 SAUF_ADDR_BUF0, SAUF_ADDR_BUF1};
  // three edges off: unit clear has surely landed
  sequence s_gate_off;
    (!peripheral_clock_gate[SAUF_GATE_BIT])[*3];
  endsequence
  sequence s_unit_rd;
    sfr_rd && sfr_addr != SAUF_ADDR_GATE;
  endsequence
  property p_rst_gate;
    $rose(rst_n) |-> peripheral_clock_gate == SAUF_RST_GATE;
  endproperty
  a_rst_gate: assert property (p_rst_gate)
    else $error("enable register not clear after reset");
  property p_gate_wr;
    sfr_wr && sfr_addr == SAUF_ADDR_GATE |=> peripheral_clock_gate ==
      ($past(peripheral_clock_gate) & ~$past(sfr_wmask) |
       $past(sfr_wdata) & $past(sfr_wmask));
  endproperty
  a_gate_wr: assert property (p_gate_wr)
    else $error("masked enable write wrong");
  property p_gate_rd;
    sfr_rd && sfr_addr == SAUF_ADDR_GATE
      |=> sfr_rdata == $past(peripheral_clock_gate);
  endproperty
  a_gate_rd: assert property (p_gate_rd)
    else $error("enable register read wrong");
  property p_gate_off;
    s_gate_off ##0 s_unit_rd |=> sfr_rdata == 8'h00;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("unit register not default while gated");
  property p_unmapped;
    sfr_rd && !mapped |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_load_busy;
    tx_loaded[0] |-> shifter_busy[0];
  endproperty
  a_load_busy: assert property (p_load_busy)
    else $error("load without shifting");
  property p_load_cause;
    tx_loaded[0] |-> $past(channel_enabled_flag[0] && channel_transmit[0]);
  endproperty
  a_load_cause: assert property (p_load_cause)
    else $error("load on idle or receiving channel");
  property p_rx_pulse;
    rx_done[1] |=> !rx_done[1];
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("receive done wider than a cycle");
  property p_rx_mode;
    rx_done[1] |-> $past(!channel_transmit[1]);
  endproperty
  a_rx_mode: assert property (p_rx_mode)
    else $error("receive done while transmitting");
endmodule

bind sauf_top sauf_assertions u_chk (.clock, .rst_n, .sfr_addr, .sfr_wr,
  .sfr_rd, .sfr_wdata, .sfr_wmask, .sfr_rdata, .peripheral_clock_gate,
  .channel_enabled_flag, .channel_transmit, .rx_done, .tx_loaded,
  .shifter_busy);

// File: test/sauf_peer.sv
// serial peer: drives the bench-given level on both lines, records a transmitted word
// assumes the bench gives the bit period in system cycles
module sauf_peer
(
  input  wire logic       clock,
  input  wire logic       tx_line,
  input  wire logic       tx_start,
  input  wire logic [7:0] period,
  input  wire logic       level,
  output logic      [1:0] rx_line,
  output logic      [7:0] word_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  assign rx_line = {2{level}};
  initial word_seen = 8'h00;
  always @(negedge clock)
  begin
    if (tx_start)
    begin
      for (int i = 0; i < 8; i++)
      begin
        word_seen[i] = tx_line;
        repeat (period) @(negedge clock);
      end
    end
  end
endmodule

// File: test/serial_unit_buffer_prescaler_tb.sv
// bench for the serial unit front end: register and shift scenarios
// assumes sauf_top, its checker and sauf_peer
module serial_unit_buffer_prescaler_tb
  import sauf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [19:0] sfr_addr = 20'h00000;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_wmask = 8'h00;
  logic [1:0]  channel_enabled_flag = 2'h0;
  logic [1:0]  channel_transmit = 2'h0;
  logic [1:0]  data_length_select = 2'h0;
  logic [1:0]  channel_clock_select = 2'h0;
  logic [7:0]  period = 8'h01;
  logic        level = 1'b1;
  logic [7:0]  sfr_rdata;
  logic [7:0]  peripheral_clock_gate;
  logic [7:0]  word_seen;
  logic [1:0]  serial_in;
  logic [1:0]  serial_out;
  logic [1:0]  rx_done;
  logic [1:0]  tx_loaded;
  logic [1:0]  shifter_busy;
  int          fails = 0;
  int          n_compared = 0;

  always #5 clock = ~clock;

  sauf_top DUT (.clock, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_wmask, .sfr_rdata, .peripheral_clock_gate, .channel_enabled_flag,
    .channel_transmit, .data_length_select, .channel_clock_select,
    .serial_in, .serial_out, .rx_done, .tx_loaded, .shifter_busy);
  sauf_peer peer (.clock, .tx_line(serial_out[0]), .tx_start(tx_loaded[0]),
    .period, .level, .rx_line(serial_in), .word_seen);

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [19:0] a,
                     input logic [7:0] d, input logic [7:0] m);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wr <= w;
    sfr_rd <= !w;
    sfr_wdata <= d;
    sfr_wmask <= m;
    @(posedge clock);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 8'hFF);
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 8'hFF);
    chk(sfr_rdata, e);
  endtask
  task automatic print_verdict;
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    rd(SAUF_ADDR_GATE, SAUF_RST_GATE);
    rd(SAUF_ADDR_PRESEL, SAUF_RST_PRESEL);
    rd(SAUF_ADDR_BUF0, SAUF_RST_BUF);
    rd(SAUF_ADDR_BUF1, SAUF_RST_BUF);
    rd(20'hF0127, 8'h00);
  endtask
  task automatic t_gate;
    wr(SAUF_ADDR_PRESEL, 8'h21);
    rd(SAUF_ADDR_PRESEL, 8'h00);
    bus(1'b1, SAUF_ADDR_GATE, 8'hFF, 8'h04);
    chk(peripheral_clock_gate, 8'h04);
    bus(1'b1, SAUF_ADDR_GATE, 8'h01, 8'h01);
    chk(peripheral_clock_gate, 8'h05);
    wr(SAUF_ADDR_GATE, 8'h04);
    wr(SAUF_ADDR_PRESEL, 8'h21);
    rd(SAUF_ADDR_PRESEL, 8'h21);
    wr(SAUF_ADDR_BUF1, 8'h5A);
    rd(SAUF_ADDR_BUF1, 8'h00);
    wr(SAUF_ADDR_GATE, 8'h00);
    rd(SAUF_ADDR_PRESEL, 8'h00);
    wr(SAUF_ADDR_GATE, 8'h04);
  endtask
  // select only rewritten with the channels stopped
  task automatic t_tx(input logic [7:0] sel, input logic cs,
                      input logic lw, input logic [7:0] w, input int k);
    int n;
    logic [7:0] m;
    n = 0;
    m = lw ? 8'hFF : 8'h7F;
    @(posedge clock);
    channel_enabled_flag <= 2'h0;
    wr(SAUF_ADDR_PRESEL, sel);
    @(posedge clock);
    channel_enabled_flag <= 2'h1;
    channel_transmit <= 2'h1;
    data_length_select <= {1'b0, lw};
    channel_clock_select <= {1'b0, cs};
    period <= 8'(1 << k);
    wr(SAUF_ADDR_BUF0, w);
    while (tx_loaded[0] !== 1'b1 && n < 300)
    begin
      @(negedge clock);
      n++;
    end
    n = 0;
    while (shifter_busy[0] === 1'b1 && n < 300)
    begin
      n++;
      @(negedge clock);
    end
    chk(8'(n), 8'((lw ? 8 : 7) << k));
    chk(word_seen & m, w & m);
    rd(SAUF_ADDR_BUF0, w);
  endtask
  task automatic t_rx(input logic lw, input logic [7:0] p,
                      input logic [7:0] e);
    int n;
    n = 0;
    @(posedge clock);
    channel_enabled_flag <= 2'h0;
    wr(SAUF_ADDR_PRESEL, 8'h00);
    @(posedge clock);
    channel_enabled_flag <= 2'h2;
    data_length_select <= {lw, 1'b0};
    channel_clock_select <= 2'h0;
    level <= p[0];
    // undivided tick: one pattern bit per cycle, lsb first
    for (int i = 1; i < 8; i++)
    begin
      @(posedge clock);
      level <= p[i];
    end
    while (rx_done[1] !== 1'b1 && n < 50)
    begin
      @(negedge clock);
      n++;
    end
    chk({7'h00, rx_done[1]}, 8'h01);
    rd(SAUF_ADDR_BUF1, e);
  endtask

  initial
  begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    t_gate;
    t_tx(8'h00, 1'b0, 1'b1, 8'hA5, 0);
    t_tx(8'h02, 1'b0, 1'b0, 8'h36, 2);
    t_tx(8'h30, 1'b1, 1'b1, 8'hC3, 3);
    t_rx(1'b0, 8'hB5, 8'h35);
    t_rx(1'b1, 8'h6C, 8'h6C);
    print_verdict;
  end
  // generous over the few hundred cycles the scenarios need
  initial
  begin
    repeat (5000) @(posedge clock);
    fails++;
    print_verdict;
  end
endmodule
